// *** clkas_top.sv ***
// alarm status registers, signal-loss sticky flags and interrupt pin
// How it works
// - live signal-loss of inputs four..one reads at bits 4..1, 1 while alarmed.
// - bit 0 of live signal-loss status reads 1 while the reference lost.
// - misc bit 7 reads 1 while the last coarse skew write is in progress.
// - misc bit 6 reads 1 only once the hold filter has enough valid samples.
// - misc bit 5 reads 1 while the frame sync alignment alarm is active.
// - live frequency-offset alarms of inputs four..one read at misc bits 4..1.
// - misc bit 0 reads 1 while the loop is unlocked, 0 while locked.
// - each signal-loss flag latches its live status and stays set until a write of 0 clears it.
// - interrupt output goes active only while the pin enable holds 1.
// - a flag whose mask bit is 1 does not drive the interrupt.
// - writing 0 to a flag bit clears that flag, unless its live status is still 1 (set wins).
`timescale 1ns/1ps
module clkas_top
  import clkas_pkg::*;
#(
  parameter int unsigned HOLD_SAMPLES = clkas_pkg::CLKAS_HOLD_SAMPLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port from the serial configuration engine
  input wire clkas_pkg::clkas_req_t req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // live alarms from the monitors
  input wire clkas_pkg::clkas_loss_t loss_live,
  input wire clkas_pkg::clkas_fos_t fos_live,
  input wire logic pll_unlock_live,
  input wire logic align_alarm_live,
  // coarse skew engine
  input wire logic coarse_skew_write,
  input wire logic coarse_skew_done,
  // digital hold filter feed
  input wire logic hold_clock_valid,
  input wire logic hold_sample_tick,
  // interrupt control from the mask and pin-enable settings
  input wire logic [4:0] sigloss_mask,
  input wire logic int_pin_enable,
  // interrupt pin
  output logic int_out
);
  import clkas_pkg::*;

  logic [4:0] loss_status;
  logic [4:0] next_loss_status;
  logic [7:0] misc_status;
  logic [7:0] next_misc_status;
  logic coarse_skew_busy;
  logic next_coarse_skew_busy;
  logic hold_filter_ready;
  logic next_hold_filter_ready;
  logic [CLKAS_CW-1:0] hold_count;
  logic [CLKAS_CW-1:0] next_hold_count;
  logic [4:0] loss_flags;
  logic [4:0] flag_clear;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic next_int_out;
  logic flag_write;

  localparam logic [CLKAS_CW-1:0] HOLD_LAST = CLKAS_CW'(HOLD_SAMPLES - 1);

  function automatic logic [7:0] clkas_read(input logic [7:0] a, input logic [4:0] ls,
                                            input logic [7:0] ms, input logic [4:0] fl);
    logic [7:0] v;
    v = CLKAS_RST_BYTE;
    case (a)
      CLKAS_OFS_SIGLOSS_STATUS: v = {3'h0, ls};
      CLKAS_OFS_ALARM_MISC: v = ms;
      CLKAS_OFS_SIGLOSS_FLAGS: v = {3'h0, fl};
      default: v = CLKAS_RST_BYTE;
    endcase
    return v;
  endfunction

  // live status capture
  always_comb begin
    next_loss_status = loss_live;
    next_misc_status = CLKAS_RST_BYTE;
    next_misc_status[CLKAS_BIT_SKEW] = coarse_skew_busy;
    next_misc_status[CLKAS_BIT_HOLD] = hold_filter_ready;
    next_misc_status[CLKAS_BIT_ALIGN] = align_alarm_live;
    next_misc_status[CLKAS_BIT_IN4:CLKAS_BIT_IN1] = fos_live;
    next_misc_status[CLKAS_BIT_UNLOCK] = pll_unlock_live;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_status <= CLKAS_RST_LOSS;
      misc_status <= CLKAS_RST_BYTE;
    end else begin
      loss_status <= next_loss_status;
      misc_status <= next_misc_status;
    end
  end

  // coarse skew tracking and hold filter fill; a new write beats a done
  always_comb begin
    next_coarse_skew_busy = coarse_skew_busy;
    if (coarse_skew_done) begin
      next_coarse_skew_busy = 1'b0;
    end
    if (coarse_skew_write) begin
      next_coarse_skew_busy = 1'b1;
    end
    next_hold_count = hold_count;
    next_hold_filter_ready = hold_filter_ready;
    if (!hold_clock_valid) begin
      // an invalid clock spoils the held average, so refill from empty
      next_hold_count = '0;
      next_hold_filter_ready = 1'b0;
    end else if (hold_sample_tick && !hold_filter_ready) begin
      next_hold_count = hold_count + CLKAS_CW'(1);
      if (hold_count == HOLD_LAST) begin
        next_hold_filter_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_skew_busy <= 1'b0;
      hold_filter_ready <= 1'b0;
      hold_count <= '0;
    end else begin
      coarse_skew_busy <= next_coarse_skew_busy;
      hold_filter_ready <= next_hold_filter_ready;
      hold_count <= next_hold_count;
    end
  end

  // writes reach only the flag bits; every other byte is read-only
  assign flag_write = req.wr_en && (req.addr == CLKAS_OFS_SIGLOSS_FLAGS);
  assign flag_clear = flag_write ? ~req.wr_data[4:0] : 5'h00;

  clkas_sticky #(
    .W(CLKAS_NLOSS)
  ) u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set(loss_status),
    .clr(flag_clear),
    .q(loss_flags)
  );

  // read data and interrupt pin, both registered
  always_comb begin
    next_rd_valid = req.rd_en;
    next_rd_data = rd_data;
    if (req.rd_en) begin
      next_rd_data = clkas_read(req.addr, loss_status, misc_status, loss_flags);
    end
    next_int_out = int_pin_enable && |(loss_flags & ~sigloss_mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= CLKAS_RST_BYTE;
      rd_valid <= 1'b0;
      int_out <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      int_out <= next_int_out;
    end
  end

  // checks
  logic armed;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear_write(int i);
    flag_write && !req.wr_data[i];
  endsequence

  property p_loss_live;
    armed |-> loss_status == $past(loss_live);
  endproperty
  a_loss_live: assert property (p_loss_live) else $error("loss status mismatch");

  property p_fos_live;
    armed |-> misc_status[4:1] == $past(fos_live);
  endproperty
  a_fos_live: assert property (p_fos_live) else $error("offset status mismatch");

  property p_unlock_align;
    armed |-> (misc_status[0] == $past(pll_unlock_live))
              && (misc_status[5] == $past(align_alarm_live));
  endproperty
  a_unlock_align: assert property (p_unlock_align) else $error("lock or align wrong");

  property p_flag_sets;
    loss_status[0] |=> loss_flags[0];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag did not latch");

  property p_flag_holds;
    loss_flags[1] && !(flag_write && !req.wr_data[1]) |=> loss_flags[1];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped by itself");

  property p_flag_clears;
    s_clear_write(2) ##0 !loss_status[2] |=> !loss_flags[2];
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("flag did not clear");

  property p_set_wins;
    s_clear_write(3) ##0 loss_status[3] |=> loss_flags[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat live alarm");

  property p_int_gate;
    armed |-> int_out == $past(int_pin_enable && |(loss_flags & ~sigloss_mask));
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt gating wrong");

  property p_skew_busy;
    coarse_skew_write |=> coarse_skew_busy ##1 misc_status[7];
  endproperty
  a_skew_busy: assert property (p_skew_busy) else $error("skew busy not shown");

  property p_hold_drop;
    !hold_clock_valid |=> !hold_filter_ready ##1 !misc_status[6];
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("hold ready with bad clock");

  property p_reserved;
    rd_valid && $past(req.addr) != CLKAS_OFS_ALARM_MISC |-> rd_data[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");
endmodule // clkas_top

// *** clkas_pkg.sv ***
// constants and types shared by the clock alarm status block
package clkas_pkg;
  localparam int unsigned CLKAS_AW = 8;
  localparam int unsigned CLKAS_DW = 8;
  localparam logic [7:0] CLKAS_OFS_SIGLOSS_STATUS = 8'h81;
  localparam logic [7:0] CLKAS_OFS_ALARM_MISC = 8'h82;
  localparam logic [7:0] CLKAS_OFS_SIGLOSS_FLAGS = 8'h83;
  localparam int unsigned CLKAS_NLOSS = 5;
  localparam int unsigned CLKAS_BIT_REF = 0;
  localparam int unsigned CLKAS_BIT_IN1 = 1;
  localparam int unsigned CLKAS_BIT_IN4 = 4;
  localparam int unsigned CLKAS_BIT_UNLOCK = 0;
  localparam int unsigned CLKAS_BIT_ALIGN = 5;
  localparam int unsigned CLKAS_BIT_HOLD = 6;
  localparam int unsigned CLKAS_BIT_SKEW = 7;
  localparam logic [7:0] CLKAS_RST_BYTE = 8'h00;
  localparam logic [4:0] CLKAS_RST_LOSS = 5'h00;
  localparam int unsigned CLKAS_HOLD_SAMPLES = 16;
  localparam int unsigned CLKAS_CW = 16;

  typedef struct packed {
    logic in4_sigloss_live;
    logic in3_sigloss_live;
    logic in2_sigloss_live;
    logic in1_sigloss_live;
    logic ref_sigloss_live;
  } clkas_loss_t;

  typedef struct packed {
    logic in4_freq_offset_live;
    logic in3_freq_offset_live;
    logic in2_freq_offset_live;
    logic in1_freq_offset_live;
  } clkas_fos_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
  } clkas_req_t;
endpackage

// *** clkas_sticky.sv ***
// sticky flag bank: set wins over a write-zero clear
`timescale 1ns/1ps
module clkas_sticky #(
  parameter int unsigned W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // held flags
  output logic [W-1:0] q
);
  logic [W-1:0] next_q;

  always_comb begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // clkas_sticky

// *** tb_top.sv ***
// self-checking bench for the clock alarm status block
`timescale 1ns/1ps
module tb_top;
  import clkas_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  clkas_req_t req = '0;
  logic [7:0] rd_data;
  logic rd_valid;
  clkas_loss_t loss_live = '0;
  clkas_fos_t fos_live = '0;
  logic pll_unlock_live = 1'b0;
  logic align_alarm_live = 1'b0;
  logic coarse_skew_write = 1'b0;
  logic coarse_skew_done = 1'b0;
  logic hold_clock_valid = 1'b0;
  logic hold_sample_tick = 1'b0;
  logic [4:0] sigloss_mask = 5'h00;
  logic int_pin_enable = 1'b0;
  logic int_out;
  int fails = 0;
  int compares = 0;

  always #5 clk = ~clk;

  // short hold count keeps the filter scenario brief
  clkas_top #(.HOLD_SAMPLES(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .loss_live(loss_live), .fos_live(fos_live), .pll_unlock_live(pll_unlock_live),
    .align_alarm_live(align_alarm_live), .coarse_skew_write(coarse_skew_write),
    .coarse_skew_done(coarse_skew_done), .hold_clock_valid(hold_clock_valid),
    .hold_sample_tick(hold_sample_tick), .sigloss_mask(sigloss_mask),
    .int_pin_enable(int_pin_enable), .int_out(int_out));

  task automatic end_of_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // every task is entered and left on a falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    req.rd_en = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd_en = 1'b0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (rd_valid !== 1'b1) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, rd_valid, 1'b1);
      end_of_test();
    end else begin
      chk(rd_data, e);
      @(negedge clk);
      chk({7'h00, rd_valid}, 8'h00);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr_en = 1'b1;
    req.addr = a;
    req.wr_data = d;
    @(negedge clk);
    req.wr_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_status();
    loss_live = 5'h15;
    fos_live = 4'ha;
    pll_unlock_live = 1'b1;
    align_alarm_live = 1'b1;
    wt(3);
    rd(CLKAS_OFS_SIGLOSS_STATUS, 8'h15);
    rd(CLKAS_OFS_ALARM_MISC, 8'h35);
    fos_live = 4'h0;
    pll_unlock_live = 1'b0;
    align_alarm_live = 1'b0;
    loss_live = 5'h00;
    wt(3);
    rd(CLKAS_OFS_SIGLOSS_STATUS, 8'h00);
    rd(CLKAS_OFS_ALARM_MISC, 8'h00);
  endtask

  task automatic t_flags();
    rd(CLKAS_OFS_SIGLOSS_FLAGS, 8'h15);
    chk({7'h00, int_out}, 8'h00);
    int_pin_enable = 1'b1;
    wt(3);
    chk({7'h00, int_out}, 8'h01);
    sigloss_mask = 5'h15;
    wt(3);
    chk({7'h00, int_out}, 8'h00);
    sigloss_mask = 5'h11;
    wt(3);
    chk({7'h00, int_out}, 8'h01);
    wr(CLKAS_OFS_SIGLOSS_FLAGS, 8'h11);
    rd(CLKAS_OFS_SIGLOSS_FLAGS, 8'h11);
    wt(2);
    chk({7'h00, int_out}, 8'h00);
    // two live alarms so the set-wins case is seen on more than one bit
    loss_live = 5'h09;
    wt(3);
    chk({7'h00, int_out}, 8'h01);
    wr(CLKAS_OFS_SIGLOSS_FLAGS, 8'h00);
    rd(CLKAS_OFS_SIGLOSS_FLAGS, 8'h09);
    loss_live = 5'h00;
    wt(3);
    wr(CLKAS_OFS_SIGLOSS_FLAGS, 8'h00);
    rd(CLKAS_OFS_SIGLOSS_FLAGS, 8'h00);
    sigloss_mask = 5'h00;
    wt(3);
    chk({7'h00, int_out}, 8'h00);
  endtask

  task automatic t_access();
    wr(CLKAS_OFS_SIGLOSS_STATUS, 8'hff);
    rd(CLKAS_OFS_SIGLOSS_STATUS, 8'h00);
    wr(CLKAS_OFS_ALARM_MISC, 8'hff);
    rd(CLKAS_OFS_ALARM_MISC, 8'h00);
    wr(CLKAS_OFS_SIGLOSS_FLAGS, 8'hff);
    rd(CLKAS_OFS_SIGLOSS_FLAGS, 8'h00);
    rd(8'h80, 8'h00);
  endtask

  task automatic t_skew();
    coarse_skew_write = 1'b1;
    @(negedge clk);
    coarse_skew_write = 1'b0;
    wt(3);
    rd(CLKAS_OFS_ALARM_MISC, 8'h80);
    coarse_skew_done = 1'b1;
    @(negedge clk);
    coarse_skew_done = 1'b0;
    wt(3);
    rd(CLKAS_OFS_ALARM_MISC, 8'h00);
    // a fresh write in the same cycle as done sets the busy bit again
    coarse_skew_write = 1'b1;
    coarse_skew_done = 1'b1;
    @(negedge clk);
    coarse_skew_write = 1'b0;
    coarse_skew_done = 1'b0;
    wt(3);
    rd(CLKAS_OFS_ALARM_MISC, 8'h80);
    coarse_skew_done = 1'b1;
    @(negedge clk);
    coarse_skew_done = 1'b0;
    wt(3);
    rd(CLKAS_OFS_ALARM_MISC, 8'h00);
  endtask

  task automatic t_hold();
    hold_clock_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 3)
        rd(CLKAS_OFS_ALARM_MISC, 8'h00);
      hold_sample_tick = 1'b1;
      @(negedge clk);
      hold_sample_tick = 1'b0;
      @(negedge clk);
    end
    wt(3);
    rd(CLKAS_OFS_ALARM_MISC, 8'h40);
    hold_clock_valid = 1'b0;
    wt(3);
    rd(CLKAS_OFS_ALARM_MISC, 8'h00);
  endtask

  initial begin
    wt(2);
    rst_n = 1'b1;
    @(negedge clk);
    rd(CLKAS_OFS_SIGLOSS_FLAGS, 8'h00);
    t_status();
    t_flags();
    t_access();
    t_skew();
    t_hold();
    end_of_test();
  end
endmodule // tb_top
